// ==== apir_pkg.sv ====
package apir_pkg;
  localparam int          NUM_PROGS      = 6;
  localparam int          SEL_W          = 2;
  localparam int          PROG_NUM_W     = 3;
  localparam logic [11:0] ROUTE_BASE_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF     = 12'h018;
  localparam int          SEL_LSB        = 0;
  localparam logic [1:0]  SEL_RESET      = 2'h0;
  localparam logic [1:0]  SEL_NONE       = 2'h0;
  localparam logic [1:0]  SEL_A          = 2'h1;
  localparam logic [1:0]  SEL_B          = 2'h2;
  localparam logic [1:0]  SEL_NONE_ALT   = 2'h3;
  localparam logic [2:0]  LAST_PROG_CODE = 3'h5;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
  localparam logic [1:0]  HRESP_OKAY     = 2'h0;
endpackage

// ==== apir_route_dec.sv ====
`timescale 1ns/1ps
module apir_route_dec (
  // select and event
  input  wire logic [1:0] sel,
  input  wire logic       fire,
  // routed requests
  output logic            to_a,
  output logic            to_b
);
  assign to_a = fire && (sel == apir_pkg::SEL_A); // RL2 RL4
  assign to_b = fire && (sel == apir_pkg::SEL_B); // RL3 RL4
  // 00 and 11 match neither compare, so they raise nothing
endmodule

// ==== apir_irq_route.sv ====
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
// Operation
// RL1: six 2-bit route selectors, one per program
// RL2: selector 01 routes interrupt to output a
// RL3: selector 10 routes interrupt to output b
// RL4: selector 00 or 11 routes nowhere
// RL5: selectors reset to zero, upper bits read zero
// RL6: 3-bit program number, 110/111 reserved
module apir_irq_route #(
  parameter int NPROG = 6
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic [1:0]       hresp,
  // program completion event from the converter
  input  wire logic        prog_done,
  input  wire logic [2:0]  prog_num,
  // interrupt outputs
  output logic             program_irq_out_a,
  output logic             program_irq_out_b
);
  // program codes above five are reserved, so more than six routes could never fire
  if (NPROG < 1 || NPROG > apir_pkg::NUM_PROGS) begin : g_chk
    $error("apir_irq_route: NPROG must lie between 1 and 6");
  end

  // the field and code widths are fixed by the register layout and the program table
  if (apir_pkg::SEL_W != 2 || apir_pkg::PROG_NUM_W != 3) begin : g_chk_w
    $error("apir_irq_route: select or program code width changed");
  end

  // bus pipeline
  logic [11:0]      addr_reg;
  logic [11:0]      addr_next;
  logic             wr_reg;
  logic             wr_next;
  logic             rd_reg;
  logic             rd_next;
  logic [31:0]      rdata_next;
  logic             xfer_ok;
  logic             xfer_act;
  logic             status_hit;
  logic [31:0]      status_word;
  logic [31:0]      route_rdata;
  logic [31:0]      rd_chain [NPROG+1];
  // route storage and routed events
  logic [1:0]       route_sel_reg [NPROG];
  logic [31:0]      route_word [NPROG];
  logic [NPROG-1:0] wr_hit;
  logic [NPROG-1:0] rd_hit;
  logic [NPROG-1:0] prog_hit;
  logic [NPROG-1:0] hit_a;
  logic [NPROG-1:0] hit_b;
  logic             prog_valid;
  // interrupt and status state
  logic             irq_a_reg;
  logic             irq_a_next;
  logic             irq_b_reg;
  logic             irq_b_next;
  logic [2:0]       last_prog_reg;
  logic [2:0]       last_prog_next;

  // address phase decode; hsize is ignored since only whole words are mapped
  assign xfer_act   = (htrans == apir_pkg::HTRANS_NONSEQ) || (htrans == apir_pkg::HTRANS_SEQ);
  assign xfer_ok    = hsel && hready && xfer_act;
  assign addr_next  = xfer_ok ? haddr : addr_reg;
  assign wr_next    = xfer_ok && hwrite;
  assign rd_next    = xfer_ok && !hwrite;
  assign prog_valid = prog_done && (prog_num <= apir_pkg::LAST_PROG_CODE); // RL6

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 12'h000;
    end else begin
      addr_reg <= addr_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 1'b0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // read data is decoded in the address phase so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= rdata_next;
    end
  end

  // zero wait states: a read right after a write to the same word sees the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= apir_pkg::HRESP_OKAY;
    end else begin
      hresp <= apir_pkg::HRESP_OKAY;
    end
  end

  genvar p;
  for (p = 0; p < NPROG; p++) begin : g_prog
    assign wr_hit[p]     = wr_reg && (addr_reg == apir_pkg::ROUTE_BASE_OFF + 12'(4 * p)); // RL1
    assign rd_hit[p]     = rd_next && (haddr == apir_pkg::ROUTE_BASE_OFF + 12'(4 * p));
    assign prog_hit[p]   = prog_valid && (prog_num == 3'(p));
    // bits 31 to 2 are not stored, so they can only read back as zero
    assign route_word[p] = {30'h0, route_sel_reg[p]}; // RL5
    assign rd_chain[p+1] = rd_chain[p] | (rd_hit[p] ? route_word[p] : 32'h0000_0000);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        route_sel_reg[p] <= apir_pkg::SEL_RESET; // RL5
      end else if (wr_hit[p]) begin
        route_sel_reg[p] <= hwdata[1:0]; // RL1
      end
    end

    apir_route_dec u_dec (
      .sel  (route_sel_reg[p]),
      .fire (prog_hit[p]),
      .to_a (hit_a[p]),
      .to_b (hit_b[p])
    );

    // per-program checks
    write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      wr_hit[p]
      |=> route_sel_reg[p] == $past(hwdata[1:0]))
      else $error("route write lost");

    keeps_value_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      !wr_hit[p]
      |=> $stable(route_sel_reg[p]))
      else $error("route changed without a write");

    read_back_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1 RL5
      rd_hit[p]
      |=> hrdata == {30'h0, $past(route_sel_reg[p])})
      else $error("route read back wrong");

    reset_value_a: assert property (@(posedge hclk) // RL5
      !hresetn
      |-> route_sel_reg[p] == apir_pkg::SEL_RESET)
      else $error("route not cleared by reset");

    route_to_a_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
      (prog_hit[p] && route_sel_reg[p] == apir_pkg::SEL_A)
      |=> program_irq_out_a && !program_irq_out_b)
      else $error("route 01 did not reach output a only");

    route_to_b_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
      (prog_hit[p] && route_sel_reg[p] == apir_pkg::SEL_B)
      |=> program_irq_out_b && !program_irq_out_a)
      else $error("route 10 did not reach output b only");

    route_none_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      (prog_hit[p] && (route_sel_reg[p] == apir_pkg::SEL_NONE ||
                       route_sel_reg[p] == apir_pkg::SEL_NONE_ALT))
      |=> !program_irq_out_a && !program_irq_out_b)
      else $error("route 00 or 11 raised an output");
  end

  // read mux: only one route word or the status word can be hit at a time
  assign rd_chain[0]  = 32'h0000_0000;
  assign route_rdata  = rd_chain[NPROG];
  assign status_hit   = rd_next && (haddr == apir_pkg::STATUS_OFF);
  assign status_word  = {27'h000_0000, irq_b_reg, irq_a_reg, last_prog_reg};
  always_comb begin
    rdata_next = route_rdata;
    if (status_hit) begin
      rdata_next = status_word;
    end
  end

  // one-cycle pulse per routed completion
  assign irq_a_next     = |hit_a; // RL2
  assign irq_b_next     = |hit_b; // RL3
  assign last_prog_next = prog_valid ? prog_num : last_prog_reg; // RL6

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_a_reg <= 1'b0;
    end else begin
      irq_a_reg <= irq_a_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_b_reg <= 1'b0;
    end else begin
      irq_b_reg <= irq_b_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_prog_reg <= 3'h0;
    end else begin
      last_prog_reg <= last_prog_next;
    end
  end

  // outputs come straight from their flops
  assign program_irq_out_a = irq_a_reg;
  assign program_irq_out_b = irq_b_reg;

  // checks on the outputs as the interrupt controller sees them
  reset_quiet_a: assert property (@(posedge hclk) // RL5
    !hresetn
    |-> !program_irq_out_a && !program_irq_out_b)
    else $error("interrupt output during reset");

  a_has_route_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
    program_irq_out_a
    |-> $past(prog_valid) && $past(route_sel_reg[prog_num]) == apir_pkg::SEL_A)
    else $error("output a without route 01");

  b_has_route_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
    program_irq_out_b
    |-> $past(prog_valid) && $past(route_sel_reg[prog_num]) == apir_pkg::SEL_B)
    else $error("output b without route 10");

  never_both_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    program_irq_out_a
    |-> !program_irq_out_b)
    else $error("both outputs at once");

  reserved_code_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    (prog_done && prog_num > apir_pkg::LAST_PROG_CODE)
    |=> !program_irq_out_a && !program_irq_out_b)
    else $error("reserved program raised irq");

  no_event_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL2 RL3
    !prog_valid
    |=> !program_irq_out_a && !program_irq_out_b)
    else $error("output without a program event");

  upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
    $past(|rd_hit)
    |-> hrdata[31:2] == 30'h0)
    else $error("upper bits not zero");

  unmapped_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(rd_next && !(|rd_hit) && !status_hit)
    |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  status_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(status_hit)
    |-> hrdata == {27'h000_0000, $past(program_irq_out_b), $past(program_irq_out_a),
                   $past(last_prog_reg)})
    else $error("status read wrong");

  last_valid_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    1'b1
    |-> last_prog_reg <= apir_pkg::LAST_PROG_CODE)
    else $error("reserved code recorded");

  last_tracks_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    prog_valid
    |=> last_prog_reg == $past(prog_num))
    else $error("last program not recorded");

  last_holds_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    !prog_valid
    |=> $stable(last_prog_reg))
    else $error("last program changed without event");

  addr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !xfer_ok
    |=> $stable(addr_reg))
    else $error("address moved without a transfer");
endmodule

// ==== apir_irq_sink.sv ====
`timescale 1ns/1ps
module apir_irq_sink (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // interrupt lines
  input  wire logic  irq_a,
  input  wire logic  irq_b,
  // pulse counts
  output logic [7:0] cnt_a,
  output logic [7:0] cnt_b
);
  // count high cycles, not edges, so a stretched pulse shows up as extra
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a <= 8'h00;
      cnt_b <= 8'h00;
    end else begin
      cnt_a <= cnt_a + {7'h00, irq_a};
      cnt_b <= cnt_b + {7'h00, irq_b};
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, prog_done;
  logic        program_irq_out_a, program_irq_out_b;
  logic [11:0] haddr;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize, prog_num;
  logic [31:0] hwdata, hrdata, r;
  logic [7:0]  ca, cb;
  int          fail_count, cmp_count, cyc;
  apir_irq_route dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .prog_done, .prog_num,
    .program_irq_out_a, .program_irq_out_b);
  apir_irq_sink sink (.clk(hclk), .rst_n(hresetn), .irq_a(program_irq_out_a),
    .irq_b(program_irq_out_b), .cnt_a(ca), .cnt_b(cb));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= apir_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task fire(input logic [2:0] n, input logic [7:0] ea, input logic [7:0] eb);
    prog_done <= 1'b1;
    prog_num <= n;
    @(posedge hclk);
    prog_done <= 1'b0;
    // the pulse stands in the next cycle and the sink counts it one edge later
    repeat (2) @(posedge hclk);
    chk({24'h0, ca}, {24'h0, ea});
    chk({24'h0, cb}, {24'h0, eb});
  endtask
  task t_reset;
    for (int p = 0; p < 6; p++) begin
      xfer(1'b0, 12'(4 * p), 32'h0);
      chk(r, 32'h0);
    end
    xfer(1'b0, 12'h040, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, apir_pkg::STATUS_OFF, 32'h0);
    chk(r, 32'h0);
    $display("test reset done");
  endtask
  task t_route;
    logic [7:0] ea, eb;
    ea = 8'h00;
    eb = 8'h00;
    for (int p = 0; p < 6; p++) begin
      for (int s = 0; s < 4; s++) begin
        xfer(1'b1, 12'(4 * p), 32'hffff_fffc | 32'(s));
        xfer(1'b0, 12'(4 * p), 32'h0);
        chk(r, 32'(s));
        ea += 8'(s == 1);
        eb += 8'(s == 2);
        fire(3'(p), ea, eb);
      end
    end
    $display("test route done");
  endtask
  task t_reserved;
    for (int p = 0; p < 6; p++) xfer(1'b1, 12'(4 * p), 32'h1);
    fire(3'h6, 8'h06, 8'h06);
    fire(3'h7, 8'h06, 8'h06);
    fire(3'h5, 8'h07, 8'h06);
    xfer(1'b0, apir_pkg::STATUS_OFF, 32'h0);
    chk(r, 32'h0000_0005);
    $display("test reserved done");
  endtask
  task t_rerst;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int p = 0; p < 6; p++) begin
      xfer(1'b0, 12'(4 * p), 32'h0);
      chk(r, 32'h0);
    end
    fire(3'h0, 8'h00, 8'h00);
    $display("test mid reset done");
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, prog_done} = 4'h0;
    haddr = 12'h000;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    prog_num = 3'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_route();
    t_reserved();
    t_rerst();
    stop_test();
  end
endmodule
